/* dv/sram_controller_test.sv */
// Self-checking bench for the static memory controller.
`timescale 1ns/1ns
module sram_controller_test;
  import sram_ctl_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  request_t request = '0;
  logic ready, memOe;
  answer_t answer;
  pins_t pins;
  logic [DATA_W-1:0] memData, lines;
  int n_fail = 0;
  int comparisons = 0;
  localparam int POWER_WAIT_SIM = 4;
  assign lines = pins.dataOe ? pins.dataOut : memData;
  sram_controller #(.POWER_WAIT(POWER_WAIT_SIM)) dut (.clk(clk),
    .reset_n(reset_n), .request(request), .ready(ready),
    .answer(answer), .pins(pins), .dataIn(lines));
  sram_model mem (.addr(pins.addr), .chipSelect_n(pins.chipSelect_n),
    .outputDrive_n(pins.outputDrive_n), .writeStrobe_n(pins.writeStrobe_n),
    .lines(lines), .memOe(memOe), .memData(memData));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [DATA_W-1:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    @(negedge clk);
    request = '{valid: 1'b1, write: wr, addr: a, data: d};
    while (ready !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    // A request that is never taken ends the run as a failure.
    if (ready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    @(negedge clk);
    request.valid = 1'b0;
  endtask
  task automatic readBack(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] exp);
    int k;
    k = 0;
    issue(1'b0, a, 4'h0);
    while (answer.valid !== 1'b1 && k < 10) begin
      @(negedge clk);
      k++;
    end
    check({3'h0, answer.valid}, 4'h1);
    check(4'(k), 4'(ACCESS_CYC));
    check(answer.data, exp);
  endtask
  // A request held through the power wait is taken only once ready rises.
  task automatic powerWait;
    @(negedge clk);
    request = '{valid: 1'b1, write: 1'b1, addr: 20'h00000, data: 4'h5};
    repeat (POWER_WAIT_SIM - 1) begin
      check({3'h0, ready}, 4'h0);
      check({3'h0, pins.chipSelect_n}, 4'h1);
      @(negedge clk);
    end
    check({3'h0, ready}, 4'h1);
    @(negedge clk);
    check({3'h0, pins.chipSelect_n}, 4'h0);
    request.valid = 1'b0;
  endtask
  task automatic edgeWords;
    issue(1'b1, 20'hfffff, 4'ha);
    issue(1'b1, 20'h80000, 4'hf);
    issue(1'b1, 20'h00001, 4'h0);
    readBack(20'hfffff, 4'ha);
    readBack(20'h80000, 4'hf);
    readBack(20'h00001, 4'h0);
    readBack(20'h00000, 4'h5);
  endtask
  task automatic rewrite;
    readBack(20'h12345, 4'hx);
    issue(1'b1, 20'hfffff, 4'h3);
    readBack(20'hfffff, 4'h3);
    readBack(20'h80000, 4'hf);
  endtask
  always @(negedge clk) begin
    if (reset_n) check({3'h0, pins.dataOe & memOe}, 4'h0);
  end
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    powerWait();
    edgeWords();
    rewrite();
    complete_run();
  end
endmodule

/* dv/sram_model.sv */
// Behavioural model of the asynchronous 1M x 4 static memory.
`timescale 1ns/1ns
module sram_model #(
  parameter int ACCESS_NS = 10
) (
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] addr,
  input wire logic chipSelect_n,
  input wire logic outputDrive_n,
  input wire logic writeStrobe_n,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] lines,
  output logic memOe,
  output logic [sram_ctl_pkg::DATA_W-1:0] memData
);
  import sram_ctl_pkg::*;
  logic [DATA_W-1:0] store [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] held = '0;
  logic [DATA_W-1:0] drive;
  logic window;
  logic inWindow = 1'b0;
  assign window = !chipSelect_n && !writeStrobe_n;
  assign memOe = !chipSelect_n && !outputDrive_n
    && writeStrobe_n;
  // The word is taken when the first of select or strobe rises; pins that
  // settle out of unknown at reset open no window and store nothing.
  always @(window) begin
    if (inWindow && window !== 1'b1) store[addr] = lines;
    inWindow = (window === 1'b1);
  end
  // Released lines show the inverse of the last word, never a stale copy.
  always @(addr or memOe or window) begin
    if (memOe) held = store.exists(addr) ? store[addr] : 'x;
    drive = memOe ? held : ~held;
  end
  // One delay serves address, select and drive paths; select falls with drive
  // on reads here, and the inverse of the last word stands until the new one arrives.
  assign #ACCESS_NS memData = drive;
endmodule

/* src/sram_controller.sv */
// Host controller that drives an asynchronous 1M x 4 static memory.
`timescale 1ns/1ns
module sram_controller #(
  parameter int POWER_WAIT = sram_ctl_pkg::POWER_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire sram_ctl_pkg::request_t request,
  output logic ready,
  output sram_ctl_pkg::answer_t answer,
  output sram_ctl_pkg::pins_t pins,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] dataIn
);
  import sram_ctl_pkg::*;

  // Refuse a wait the counter cannot hold, or a read access count shorter than the read cycle.
  if (POWER_WAIT < 1 || POWER_WAIT >= (1 << CNT_W)) begin : g_badWait
    $error("POWER_WAIT out of range");
  end
  if (ACCESS_CYC * CLK_NS < READ_CYCLE_NS) begin : g_badAccess
    $error("read access count shorter than the read cycle");
  end

  typedef struct packed {
    state_t state;
    logic [CNT_W-1:0] count;
    pins_t pins;
    answer_t answer;
  } ctl_t;

  ctl_t cur;
  ctl_t next_cur;

  localparam logic [CNT_W-1:0] POWER_LOAD = CNT_W'(POWER_WAIT - 1);
  localparam logic [CNT_W-1:0] ACCESS_LOAD = CNT_W'(ACCESS_CYC - 1);
  localparam logic [CNT_W-1:0] FLOAT_LOAD = CNT_W'(FLOAT_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);
  // Step counts for the sequence delays in the checks below.
  localparam int FLOAT_STEPS = FLOAT_CYC;
  localparam int PULSE_STEPS = PULSE_CYC;
  localparam int ACCESS_STEPS = ACCESS_CYC;

  assign ready = (cur.state == S_IDLE);
  assign answer = cur.answer;
  assign pins = cur.pins;

  always_comb begin
    next_cur = cur;
    next_cur.answer.valid = 1'b0;
    case (cur.state)
      S_POWER: begin
        // Selection held off through the power-up wait.
        if (cur.count == '0) begin
          next_cur.state = S_IDLE;
        end else begin
          next_cur.count = cur.count - 1'b1;
        end
      end
      S_IDLE: begin
        // Address is placed in the same edge as select falls.
        if (request.valid) begin
          next_cur.pins.addr = request.addr;
          next_cur.pins.chipSelect_n = 1'b0;
          if (request.write) begin
            // Drive released first so the memory floats before data.
            next_cur.pins.outputDrive_n = 1'b1;
            next_cur.pins.dataOut = request.data;
            next_cur.count = FLOAT_LOAD;
            next_cur.state = S_WFLOAT;
          end else begin
            next_cur.pins.outputDrive_n = 1'b0;
            next_cur.count = ACCESS_LOAD;
            next_cur.state = S_READ;
          end
        end
      end
      S_READ: begin
        if (cur.count == '0) begin
          next_cur.answer.valid = 1'b1;
          next_cur.answer.data = dataIn;
          next_cur.pins.chipSelect_n = 1'b1;
          next_cur.pins.outputDrive_n = 1'b1;
          next_cur.state = S_IDLE;
        end else begin
          next_cur.count = cur.count - 1'b1;
        end
      end
      S_WFLOAT: begin
        if (cur.count == '0) begin
          next_cur.pins.dataOe = 1'b1;
          next_cur.pins.writeStrobe_n = 1'b0;
          next_cur.count = PULSE_LOAD;
          next_cur.state = S_WPULSE;
        end else begin
          next_cur.count = cur.count - 1'b1;
        end
      end
      S_WPULSE: begin
        // Strobe ends the write; data stays one more cycle for hold.
        if (cur.count == '0) begin
          next_cur.pins.writeStrobe_n = 1'b1;
          next_cur.state = S_WEND;
        end else begin
          next_cur.count = cur.count - 1'b1;
        end
      end
      S_WEND: begin
        next_cur.pins.dataOe = 1'b0;
        next_cur.pins.chipSelect_n = 1'b1;
        next_cur.state = S_IDLE;
      end
      default: begin
        next_cur.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur.state <= S_POWER;
      cur.count <= POWER_LOAD;
      cur.pins.addr <= '0;
      cur.pins.chipSelect_n <= 1'b1;
      cur.pins.outputDrive_n <= 1'b1;
      cur.pins.writeStrobe_n <= 1'b1;
      cur.pins.dataOut <= '0;
      cur.pins.dataOe <= 1'b0;
      cur.answer <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Every check runs on the one clock and rests while reset is applied.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_strobeLow;
    !pins.writeStrobe_n;
  endsequence

  sequence s_strobeRise;
    $rose(pins.writeStrobe_n);
  endsequence

  // A write opens with select falling while the memory output is off.
  sequence s_writeStart;
    $fell(pins.chipSelect_n) && pins.outputDrive_n;
  endsequence

  sequence s_writeStrobe;
    !pins.writeStrobe_n && pins.dataOe && !pins.chipSelect_n;
  endsequence

  sequence s_writeRelease;
    pins.writeStrobe_n && !pins.dataOe && pins.chipSelect_n;
  endsequence

  // A read opens with select and output drive falling together.
  sequence s_readStart;
    $fell(pins.chipSelect_n) && !pins.outputDrive_n;
  endsequence

  a_power_wait_select: assert property (
    (cur.state == S_POWER) |-> pins.chipSelect_n)
    else $error("select asserted during power-up wait");

  a_no_data_clash: assert property (
    pins.dataOe |-> pins.outputDrive_n)
    else $error("controller drives data while memory output enabled");

  a_strobe_in_select: assert property (
    s_strobeLow |-> !pins.chipSelect_n)
    else $error("strobe low outside selection");

  a_data_before_strobe: assert property (
    $fell(pins.writeStrobe_n) |-> pins.dataOe && $past(pins.outputDrive_n))
    else $error("write strobe started before float delay");

  a_data_hold_end: assert property (
    s_strobeRise |-> (pins.dataOe && $stable(pins.dataOut)) ##1
    (!pins.dataOe && pins.chipSelect_n))
    else $error("write data not held past strobe rise");

  a_read_answer_time: assert property (
    (ready && request.valid && !request.write) |=> !pins.chipSelect_n
    ##[1:8] answer.valid)
    else $error("read answer not within bound");

  a_addr_with_select: assert property (
    $fell(pins.chipSelect_n) |-> pins.addr == $past(request.addr))
    else $error("address not set with select fall");

  a_addr_stable_sel: assert property (
    (!pins.chipSelect_n && !$fell(pins.chipSelect_n)) |-> $stable(pins.addr))
    else $error("address moved while selected");

  a_write_float_first: assert property (
    s_writeStart |-> !pins.dataOe ##FLOAT_STEPS s_writeStrobe)
    else $error("write data driven before the float delay ran out");

  a_strobe_width: assert property (
    $fell(pins.writeStrobe_n) |-> ##PULSE_STEPS s_strobeRise)
    else $error("write strobe pulse of wrong length");

  a_write_release: assert property (
    s_strobeRise |=> s_writeRelease)
    else $error("write not released one cycle after strobe rise");

  a_drive_off_write: assert property (
    s_strobeLow |-> pins.outputDrive_n)
    else $error("memory output enabled during write strobe");

  a_oe_in_select: assert property (
    pins.dataOe |-> !pins.chipSelect_n)
    else $error("data driven while memory deselected");

  a_data_steady: assert property (
    (pins.dataOe && $past(pins.dataOe)) |-> $stable(pins.dataOut))
    else $error("write data changed while driven");

  a_read_no_drive: assert property (
    s_readStart |-> (pins.writeStrobe_n && !pins.dataOe))
    else $error("read started with strobe or data drive active");

  a_read_length: assert property (
    s_readStart |-> ##ACCESS_STEPS ($rose(pins.chipSelect_n) && answer.valid))
    else $error("read select length or answer timing wrong");

  a_answer_pulse: assert property (
    answer.valid |=> !answer.valid)
    else $error("answer valid held longer than one cycle");

  a_idle_deselect: assert property (
    ready |-> (pins.chipSelect_n && pins.writeStrobe_n && !pins.dataOe))
    else $error("memory left selected while idle");

  a_busy_no_start: assert property (
    !ready |=> !$fell(pins.chipSelect_n))
    else $error("access started while not ready");
endmodule

/* src/sram_ctl_pkg.sv */
// Constants and types for the asynchronous 1M x 4 static memory controller.
// Function
// - Controller times data setup and hold to the edge ending the write.
// - Controller waits at least 100 us after power before any access.
// - Reads last at least 10 ns; data is valid 10 ns after address.
// - Controller sets the address no later than select falls.
// - Strobe-ended write with drive low lasts float delay plus data setup.
// - Controller must not drive data while the memory still drives it.
// - Controller holds select high before lowering supply to retention; the controller has no supply or retention control.
package sram_ctl_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 4;
  localparam int CLK_NS = 20;
  localparam int POWER_US = 100;
  localparam int POWER_CYC = (POWER_US * 1000) / CLK_NS;
  localparam int READ_CYCLE_NS = 10;
  localparam int ADDR_ACCESS_NS = 10;
  localparam int DRIVE_FLOAT_NS = 5;
  localparam int DATA_SETUP_NS = 5;
  localparam int WRITE_PULSE_NS = 7;
  // Least times round up to whole cycles, never below one.
  localparam int ACCESS_CYC = (ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLOAT_CYC = (DRIVE_FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC =
    (WRITE_PULSE_NS + DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } request_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } answer_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chipSelect_n;
    logic outputDrive_n;
    logic writeStrobe_n;
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
  } pins_t;

  typedef enum logic [2:0] {
    S_POWER, S_IDLE, S_READ, S_WFLOAT, S_WPULSE, S_WEND
  } state_t;
endpackage
